// *** hdl/dcf_fifo_flags.sv ***
/*
 Nine-bit FIFO with full, almost-full, empty and almost-empty flags,
 offset register load and readback, and reset-time mode selection.
 Assumes writer and reader share clk_sys and all inputs but arst_n are synchronous
 to it; the bus wire is resolved outside from read_data_oe.
*/
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Full flag low, writes refused, once stored count reaches depth.
// - Full and almost-full flags change only on the write-side clock edge.
// - Empty flag low, reads refused, while stored count is zero.
// - Empty and almost-empty flags change only on the read-side clock edge.
// - Almost-full low once count reaches depth minus full offset.
// - Full offset defaults to seven.
// - Almost-empty low while fewer than n+1 words are stored.
// - Empty offset defaults to seven.
// - Flag levels follow the stored count table from zero to depth.
// - Load pin level during reset selects second enable or offset load.
// - After reset data reads zero when enabled, floats when disabled.
// - Reset works with clocks running throughout.
// - Full flag change may slip one write edge under close skew.
// - Empty flag change may slip one read edge under close skew.
// - Partial flag changes may slip one own-clock edge under skew.
// - First word after empty appears within one or two read periods.
// - In two-enable mode either inactive enable blocks the write.
// - Almost-full asserted alongside a write reflects the pre-write count.
// - Reset clears pointers, sets flag levels, output and default offsets.
// - Load mode writes the four offsets in fixed order, then wraps.
// - Output register loads only when both read enables are low.
module dcf_fifo_flags #(
    parameter int DEPTH = 64
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic reset_n,
    input wire logic write_enable_primary_n,
    input wire logic write_enable_second_or_load,
    input wire logic [dcf_pkg::DATA_W-1:0] write_data_in,
    input wire logic read_enable_a_n,
    input wire logic read_enable_b_n,
    input wire logic output_enable_n,
    output logic [dcf_pkg::DATA_W-1:0] read_data_out,
    output logic read_data_oe,
    output logic full_flag_n,
    output logic almost_full_flag_n,
    output logic empty_flag_n,
    output logic almost_empty_flag_n,
    output logic load_mode
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [dcf_pkg::CNT_W-1:0] DEPTH_C = dcf_pkg::CNT_W'(DEPTH);
    localparam logic [dcf_pkg::PTR_W-1:0] LAST_ADDR = dcf_pkg::PTR_W'(DEPTH - 1);

    dcf_pkg::dcf_state_t s_r;
    dcf_pkg::dcf_state_t s_nxt;
    logic [dcf_pkg::DATA_W-1:0] mem_r [DEPTH];

    logic wr_req;
    logic wr_go;
    logic ld_wr;
    logic rd_req;
    logic ld_rd;
    logic rd_go;
    logic [dcf_pkg::CNT_W-1:0] n_ofs;
    logic [dcf_pkg::CNT_W-1:0] m_ofs;

    function automatic logic [dcf_pkg::PTR_W-1:0] next_addr(
        input logic [dcf_pkg::PTR_W-1:0] a
    );
        if (a == LAST_ADDR) begin
            next_addr = dcf_pkg::PTR_RESET;
        end else begin
            next_addr = a + 13'h0001;
        end
    endfunction

    function automatic dcf_pkg::dcf_ofs_sel_t next_sel(input dcf_pkg::dcf_ofs_sel_t s);
        case (s)
            dcf_pkg::DCF_SEL_EMPTY_LO: next_sel = dcf_pkg::DCF_SEL_EMPTY_HI;
            dcf_pkg::DCF_SEL_EMPTY_HI: next_sel = dcf_pkg::DCF_SEL_FULL_LO;
            dcf_pkg::DCF_SEL_FULL_LO: next_sel = dcf_pkg::DCF_SEL_FULL_HI;
            default: next_sel = dcf_pkg::DCF_SEL_EMPTY_LO;
        endcase
    endfunction

    function automatic dcf_pkg::dcf_flags_t flags_of(
        input logic [dcf_pkg::CNT_W-1:0] cnt,
        input logic [dcf_pkg::CNT_W-1:0] n,
        input logic [dcf_pkg::CNT_W-1:0] m
    );
        flags_of.full_n = (cnt != DEPTH_C);
        flags_of.almost_full_n = (cnt < DEPTH_C - m);
        flags_of.almost_empty_n = (cnt > n);
        flags_of.empty_n = (cnt != dcf_pkg::CNT_RESET);
    endfunction

    always_comb begin
        s_nxt = s_r;
        n_ofs = dcf_pkg::CNT_W'({s_r.ofs_empty_hi, s_r.ofs_empty_lo});
        m_ofs = dcf_pkg::CNT_W'({s_r.ofs_full_hi, s_r.ofs_full_lo});
        // Same condition for both modes: second enable high, first low
        wr_req = reset_n && !write_enable_primary_n && write_enable_second_or_load;
        wr_go = wr_req && (s_r.cnt != DEPTH_C);
        ld_wr = reset_n && s_r.load_mode && !write_enable_primary_n
            && !write_enable_second_or_load;
        rd_req = reset_n && !read_enable_a_n && !read_enable_b_n;
        ld_rd = rd_req && s_r.load_mode && !write_enable_second_or_load;
        rd_go = rd_req && !ld_rd && (s_r.cnt != dcf_pkg::CNT_RESET);

        if (wr_go) begin
            s_nxt.wr_addr = next_addr(s_r.wr_addr);
        end
        if (rd_go) begin
            s_nxt.rd_addr = next_addr(s_r.rd_addr);
            s_nxt.dout = mem_r[s_r.rd_addr[AW-1:0]];
        end else if (ld_rd) begin
            case (s_r.rd_sel)
                dcf_pkg::DCF_SEL_EMPTY_LO: s_nxt.dout = {1'h0, s_r.ofs_empty_lo};
                dcf_pkg::DCF_SEL_EMPTY_HI: s_nxt.dout = {1'h0, s_r.ofs_empty_hi};
                dcf_pkg::DCF_SEL_FULL_LO: s_nxt.dout = {1'h0, s_r.ofs_full_lo};
                default: s_nxt.dout = {1'h0, s_r.ofs_full_hi};
            endcase
            s_nxt.rd_sel = next_sel(s_r.rd_sel);
        end

        if (wr_go && !rd_go) begin
            s_nxt.cnt = s_r.cnt + 14'h0001;
        end else if (rd_go && !wr_go) begin
            s_nxt.cnt = s_r.cnt - 14'h0001;
        end

        // Offsets are only eight bits wide each; data bit 8 above the offset width is ignored
        if (ld_wr) begin
            case (s_r.wr_sel)
                dcf_pkg::DCF_SEL_EMPTY_LO: s_nxt.ofs_empty_lo = write_data_in[7:0];
                dcf_pkg::DCF_SEL_EMPTY_HI: s_nxt.ofs_empty_hi = write_data_in[7:0];
                dcf_pkg::DCF_SEL_FULL_LO: s_nxt.ofs_full_lo = write_data_in[7:0];
                default: s_nxt.ofs_full_hi = write_data_in[7:0];
            endcase
            s_nxt.wr_sel = next_sel(s_r.wr_sel);
        end

        // Flags sample the count before this edge's transfers: one edge of
        // latency, within the allowed skew slip, and never lets the array
        // overrun because acceptance looks at the live count instead.
        s_nxt.flags = flags_of(s_r.cnt, n_ofs, m_ofs);
        // One shared clock: pointers are seen directly, no crossing needed
        s_nxt.oe = !output_enable_n;

        if (!reset_n) begin
            s_nxt = dcf_pkg::STATE_RESET;
            s_nxt.load_mode = !write_enable_second_or_load;
            s_nxt.oe = !output_enable_n;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= dcf_pkg::STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Array has no reset; contents before the first write are undefined
    always_ff @(posedge clk_sys) begin
        if (wr_go) begin
            mem_r[s_r.wr_addr[AW-1:0]] <= write_data_in;
        end
    end

    assign read_data_out = s_r.dout;
    assign read_data_oe = s_r.oe;
    assign full_flag_n = s_r.flags.full_n;
    assign almost_full_flag_n = s_r.flags.almost_full_n;
    assign empty_flag_n = s_r.flags.empty_n;
    assign almost_empty_flag_n = s_r.flags.almost_empty_n;
    assign load_mode = s_r.load_mode;

    a_full_at_depth:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt == DEPTH_C |=> !reset_n || !full_flag_n)
        else $error("full flag not low at depth");

    a_no_overflow:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt == DEPTH_C && !rd_go
            |=> s_r.cnt == DEPTH_C && $stable(s_r.wr_addr))
        else $error("write accepted while full");

    a_empty_at_zero:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt == dcf_pkg::CNT_RESET |=> !reset_n || !empty_flag_n)
        else $error("empty flag not low at zero");

    a_no_underflow:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_r.cnt == dcf_pkg::CNT_RESET |=> !$past(reset_n) || $stable(s_r.rd_addr))
        else $error("read pointer moved while empty");

    a_af_threshold:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt >= DEPTH_C - m_ofs |=> !reset_n || !almost_full_flag_n)
        else $error("almost-full flag late");

    a_ae_threshold:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n ##1 reset_n |-> almost_empty_flag_n == ($past(s_r.cnt) > $past(n_ofs)))
        else $error("almost-empty flag disagrees with count");

    a_mid_all_high:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt > n_ofs && s_r.cnt < DEPTH_C - m_ofs
            |=> !reset_n || (full_flag_n && almost_full_flag_n
            && almost_empty_flag_n && empty_flag_n))
        else $error("flags not all high in middle band");

    a_reset_state:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        !reset_n |=> full_flag_n && almost_full_flag_n && !empty_flag_n
            && !almost_empty_flag_n && read_data_out == dcf_pkg::DOUT_RESET
            && n_ofs == 14'h0007 && m_ofs == 14'h0007)
        else $error("reset values wrong");

    a_mode_latch:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        !reset_n |=> load_mode == !$past(write_enable_second_or_load))
        else $error("mode not latched from load pin");

    a_second_enable:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        (!write_enable_second_or_load || write_enable_primary_n)
            |=> $stable(s_r.wr_addr) || !$past(reset_n))
        else $error("write taken with an enable inactive");

    a_dout_hold:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && (read_enable_a_n || read_enable_b_n)
            |=> !reset_n || $stable(read_data_out))
        else $error("output register changed without read");

    a_load_order:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        ld_wr && s_r.wr_sel == dcf_pkg::DCF_SEL_FULL_HI
            |=> !reset_n || (s_r.wr_sel == dcf_pkg::DCF_SEL_EMPTY_LO
            && s_r.ofs_full_hi == $past(write_data_in[7:0])))
        else $error("offset load sequence wrong");

    // Count underneath every flag, then the pointers; a count slip skews all four
    a_cnt_bound:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_r.cnt <= DEPTH_C)
        else $error("count beyond depth");

    a_cnt_up:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && !rd_go |=> s_r.cnt == $past(s_r.cnt) + 14'h0001)
        else $error("count missed a write");

    a_cnt_down:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_go && !wr_go |=> s_r.cnt == $past(s_r.cnt) - 14'h0001)
        else $error("count missed a read");

    a_cnt_hold:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && wr_go == rd_go |=> $stable(s_r.cnt))
        else $error("count moved without net transfer");

    a_wr_wrap:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && s_r.wr_addr == LAST_ADDR |=> s_r.wr_addr == dcf_pkg::PTR_RESET)
        else $error("write pointer did not wrap at depth");

    a_wr_step:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_go && s_r.wr_addr != LAST_ADDR
            |=> s_r.wr_addr == $past(s_r.wr_addr) + 13'h0001)
        else $error("write pointer step wrong");

    a_rd_wrap:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_go && s_r.rd_addr == LAST_ADDR |=> s_r.rd_addr == dcf_pkg::PTR_RESET)
        else $error("read pointer did not wrap at depth");

    a_rd_step:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_go && s_r.rd_addr != LAST_ADDR
            |=> s_r.rd_addr == $past(s_r.rd_addr) + 13'h0001)
        else $error("read pointer step wrong");

    a_full_release:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt != DEPTH_C |=> full_flag_n)
        else $error("full flag low below depth");

    a_empty_release:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt != dcf_pkg::CNT_RESET |=> empty_flag_n)
        else $error("empty flag low with words stored");

    a_af_release:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt < DEPTH_C - m_ofs |=> almost_full_flag_n)
        else $error("almost-full flag low too early");

    a_ae_low_band:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && s_r.cnt <= n_ofs |=> !almost_empty_flag_n)
        else $error("almost-empty flag high too early");

    a_dout_word:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        rd_go |=> read_data_out == $past(mem_r[s_r.rd_addr[AW-1:0]]))
        else $error("read returned the wrong word");

    // Readback keeps its own sequence pointer, apart from the load one
    a_readback_lo:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        ld_rd && s_r.rd_sel == dcf_pkg::DCF_SEL_EMPTY_LO
            |=> read_data_out == {1'h0, $past(s_r.ofs_empty_lo)})
        else $error("offset readback value wrong");

    a_readback_wrap:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        ld_rd && s_r.rd_sel == dcf_pkg::DCF_SEL_FULL_HI
            |=> s_r.rd_sel == dcf_pkg::DCF_SEL_EMPTY_LO)
        else $error("offset readback did not wrap");

    a_ofs_locked:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        reset_n && !s_r.load_mode |=> $stable(n_ofs) && $stable(m_ofs))
        else $error("offset changed in two-enable mode");

    a_oe_follow:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        1'h1 |=> read_data_oe == !$past(output_enable_n))
        else $error("output enable not registered");

    a_seq_restart:
    assert property (@(posedge clk_sys) disable iff (!arst_n)
        !reset_n |=> s_r.cnt == dcf_pkg::CNT_RESET
            && s_r.wr_sel == dcf_pkg::DCF_SEL_EMPTY_LO
            && s_r.rd_sel == dcf_pkg::DCF_SEL_EMPTY_LO)
        else $error("reset left count or sequence behind");

endmodule

`default_nettype wire

// *** hdl/dcf_pkg.sv ***
/*
 Shared constants and types for the FIFO with status flags: data and
 offset widths, default offsets, reset values and the state record.
 Assumes the FIFO depth never exceeds 8192 words, so 14 count bits suffice.
*/
package dcf_pkg;

    localparam int DATA_W = 9;
    localparam int OFS_W = 8;
    localparam int PTR_W = 13;
    localparam int CNT_W = 14;

    localparam logic [OFS_W-1:0] OFS_DEFAULT_LO = 8'h07;
    localparam logic [OFS_W-1:0] OFS_DEFAULT_HI = 8'h00;
    localparam logic [PTR_W-1:0] PTR_RESET = 13'h0000;
    localparam logic [CNT_W-1:0] CNT_RESET = 14'h0000;
    localparam logic [DATA_W-1:0] DOUT_RESET = 9'h000;

    typedef enum logic [1:0] {
        DCF_SEL_EMPTY_LO = 2'b00,
        DCF_SEL_EMPTY_HI = 2'b01,
        DCF_SEL_FULL_LO = 2'b10,
        DCF_SEL_FULL_HI = 2'b11
    } dcf_ofs_sel_t;

    typedef struct packed {
        logic full_n;
        logic almost_full_n;
        logic almost_empty_n;
        logic empty_n;
    } dcf_flags_t;

    localparam dcf_flags_t FLAGS_RESET = '{
        full_n: 1'h1,
        almost_full_n: 1'h1,
        almost_empty_n: 1'h0,
        empty_n: 1'h0
    };

    typedef struct packed {
        logic [PTR_W-1:0] wr_addr;
        logic [PTR_W-1:0] rd_addr;
        logic [CNT_W-1:0] cnt;
        logic [OFS_W-1:0] ofs_empty_lo;
        logic [OFS_W-1:0] ofs_empty_hi;
        logic [OFS_W-1:0] ofs_full_lo;
        logic [OFS_W-1:0] ofs_full_hi;
        dcf_ofs_sel_t wr_sel;
        dcf_ofs_sel_t rd_sel;
        logic load_mode;
        dcf_flags_t flags;
        logic [DATA_W-1:0] dout;
        logic oe;
    } dcf_state_t;

    localparam dcf_state_t STATE_RESET = '{
        wr_addr: PTR_RESET,
        rd_addr: PTR_RESET,
        cnt: CNT_RESET,
        ofs_empty_lo: OFS_DEFAULT_LO,
        ofs_empty_hi: OFS_DEFAULT_HI,
        ofs_full_lo: OFS_DEFAULT_LO,
        ofs_full_hi: OFS_DEFAULT_HI,
        wr_sel: DCF_SEL_EMPTY_LO,
        rd_sel: DCF_SEL_EMPTY_LO,
        load_mode: 1'h1,
        flags: FLAGS_RESET,
        dout: DOUT_RESET,
        oe: 1'h0
    };

endpackage

// *** sim/dcf_far_end.sv ***
/*
 Far-end model: writer and reader logic driving the block's pins.
 Assumes the block samples every pin on the rising edge of clk_sys.
*/
`timescale 1ns/1ns
`default_nettype none
module dcf_far_end (
    input wire logic clk_sys,
    output logic wen_n,
    output logic sec_ld,
    output logic [dcf_pkg::DATA_W-1:0] din,
    output logic ren_a_n,
    output logic ren_b_n
);
    logic sec_idle = 1'h0;
    initial begin
        wen_n = 1'h1;
        sec_ld = 1'h0;
        din = 9'h000;
        ren_a_n = 1'h1;
        ren_b_n = 1'h1;
    end
    // Level held through reset picks the mode
    task automatic set_mode(input logic s);
        @(negedge clk_sys);
        sec_idle = s;
        sec_ld = s;
    endtask
    // s high writes a word; s low loads an offset or is blocked
    task automatic put(input logic [dcf_pkg::DATA_W-1:0] d, input logic s);
        @(negedge clk_sys);
        wen_n = 1'h0;
        sec_ld = s;
        din = d;
        @(negedge clk_sys);
        wen_n = 1'h1;
        sec_ld = sec_idle;
        din = ~d; // Released bus must not show a stale word
    endtask
    // Second pin high so a read never turns into offset readback
    task automatic get(input logic a_n, input logic b_n);
        @(negedge clk_sys);
        ren_a_n = a_n;
        ren_b_n = b_n;
        sec_ld = 1'h1;
        @(negedge clk_sys);
        ren_a_n = 1'h1;
        ren_b_n = 1'h1;
        sec_ld = sec_idle;
    endtask
    // Second pin low with both read enables: offset readback
    task automatic get_ofs();
        @(negedge clk_sys);
        ren_a_n = 1'h0;
        ren_b_n = 1'h0;
        sec_ld = 1'h0;
        @(negedge clk_sys);
        ren_a_n = 1'h1;
        ren_b_n = 1'h1;
        sec_ld = sec_idle;
    endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
/*
 Testbench: reset, fill, drain, offset load and two-enable mode.
 Assumes the far-end model drives every write and read side pin except oe_n, which the testbench drives itself.
*/
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    localparam int D = 64;
    logic clk_sys = 1'h0;
    logic arst_n = 1'h0;
    logic reset_n = 1'h0;
    logic oe_n = 1'h0;
    logic wen_n, sec, ra_n, rb_n, oe, full_n, afull_n, empty_n, aempty_n, lm;
    logic [dcf_pkg::DATA_W-1:0] din, dout;
    int num_errors = 0;
    int n_compared = 0;
    wire logic [3:0] fl = {full_n, afull_n, aempty_n, empty_n};
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    dcf_far_end dcf_far_end_i (.clk_sys(clk_sys), .wen_n(wen_n), .sec_ld(sec), .din(din),
        .ren_a_n(ra_n), .ren_b_n(rb_n));
    dcf_fifo_flags #(.DEPTH(D)) dcf_fifo_flags_i (.clk_sys(clk_sys), .arst_n(arst_n),
        .reset_n(reset_n), .write_enable_primary_n(wen_n),
        .write_enable_second_or_load(sec), .write_data_in(din), .read_enable_a_n(ra_n),
        .read_enable_b_n(rb_n), .output_enable_n(oe_n), .read_data_out(dout),
        .read_data_oe(oe), .full_flag_n(full_n), .almost_full_flag_n(afull_n),
        .empty_flag_n(empty_n), .almost_empty_flag_n(aempty_n), .load_mode(lm));
    // Expected {full, almost full, almost empty, empty}, all active low
    function automatic logic [3:0] ex(input int c, input int n, input int m);
        return {c != D, c < D - m, c > n, c != 0};
    endfunction
    task automatic wrap_up();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Clock keeps running through reset
    task automatic do_reset(input logic s);
        dcf_far_end_i.set_mode(s);
        arst_n = 1'h0;
        reset_n = 1'h0;
        repeat (8) @(negedge clk_sys);
        arst_n = 1'h1;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'h1;
        @(negedge clk_sys);
    endtask
    task automatic t_reset();
        do_reset(1'h0);
        `CHK(fl, 4'hc)
        `CHK(dout, 9'h000)
        `CHK(lm, 1'h1)
        `CHK(oe, 1'h1)
        oe_n = 1'h1;
        repeat (2) @(negedge clk_sys);
        `CHK(oe, 1'h0)
        oe_n = 1'h0;
    endtask
    // Flags lag the count by one edge, so look after a spare edge
    task automatic fill(input int n, input int m);
        for (int k = 1; k <= D; k++) begin
            dcf_far_end_i.put(9'(k), 1'h1);
            @(negedge clk_sys);
            `CHK(fl, ex(k, n, m))
        end
        dcf_far_end_i.put(9'h1ff, 1'h1);
        @(negedge clk_sys);
        `CHK(fl, ex(D, n, m))
    endtask
    task automatic drain(input int n, input int m);
        dcf_far_end_i.get(1'h1, 1'h0);
        @(negedge clk_sys);
        `CHK(dout, 9'h000)
        dcf_far_end_i.get(1'h0, 1'h1);
        @(negedge clk_sys);
        `CHK(dout, 9'h000)
        `CHK(fl, ex(D, n, m))
        for (int k = 1; k <= D; k++) begin
            dcf_far_end_i.get(1'h0, 1'h0);
            @(negedge clk_sys);
            `CHK(dout, 9'(k))
            `CHK(fl, ex(D - k, n, m))
        end
        dcf_far_end_i.get(1'h0, 1'h0);
        @(negedge clk_sys);
        `CHK(dout, 9'(D))
        `CHK(fl, ex(0, n, m))
    endtask
    // Fifth load wraps back to the low empty offset; readback follows it
    task automatic t_load();
        logic [dcf_pkg::DATA_W-1:0] v[5];
        logic [dcf_pkg::DATA_W-1:0] e[5];
        v = '{9'h003, 9'h000, 9'h005, 9'h000, 9'h002};
        e = '{9'h002, 9'h000, 9'h005, 9'h000, 9'h002};
        do_reset(1'h0);
        foreach (v[i]) dcf_far_end_i.put(v[i], 1'h0);
        fill(2, 5);
        drain(2, 5);
        foreach (e[i]) begin
            dcf_far_end_i.get_ofs();
            `CHK(dout, e[i])
            `CHK(fl, ex(0, 2, 5))
        end
    endtask
    task automatic t_two();
        do_reset(1'h1);
        `CHK(lm, 1'h0)
        dcf_far_end_i.put(9'h0aa, 1'h0);
        @(negedge clk_sys);
        `CHK(fl, ex(0, 7, 7))
        dcf_far_end_i.put(9'h055, 1'h1);
        @(negedge clk_sys);
        `CHK(fl, ex(1, 7, 7))
        dcf_far_end_i.get(1'h0, 1'h0);
        @(negedge clk_sys);
        `CHK(dout, 9'h055)
        `CHK(fl, ex(0, 7, 7))
    endtask
    initial begin
        t_reset();
        fill(7, 7);
        drain(7, 7);
        t_load();
        t_two();
        wrap_up();
    end
    // About 1000 cycles expected; cut off well beyond
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
endmodule
`default_nettype wire
